// >>> inc/slpg_pkg.sv
// Purpose: shared constants and types for the status lamp pattern generator
// Assumes: 100 MHz clock, millisecond tick made inside the block
// Notes: all pattern timing is in whole milliseconds
package slpg_pkg;

    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    localparam int unsigned SLOT_MS = 250;
    localparam int unsigned BLINK5_MS = 100;
    localparam int unsigned FLICK_MS = 50;
    localparam int unsigned CYCLE_MS = 3000;
    localparam logic [11:0] SLOT_LAST = 12'(SLOT_MS - 1);
    localparam logic [11:0] BLINK5_LAST = 12'(BLINK5_MS - 1);
    localparam logic [11:0] FLICK_LAST = 12'(FLICK_MS - 1);
    localparam logic [3:0] SLOTS_LAST = 4'(CYCLE_MS / SLOT_MS - 1);
    localparam int unsigned PORTS = 2;

    // duo lamp colour
    typedef enum logic [1:0] {
        SLPG_DARK,
        SLPG_GREEN,
        SLPG_ORANGE,
        SLPG_RED
    } slpg_colour_type;

    // motion-bus slave state selected by firmware
    typedef enum logic [3:0] {
        SLPG_NON_REALTIME,
        SLPG_PHASE_ZERO,
        SLPG_PHASE_ONE,
        SLPG_PHASE_TWO,
        SLPG_PHASE_THREE,
        SLPG_PHASE_FOUR,
        SLPG_HOTPLUG_ZERO,
        SLPG_HOTPLUG_ONE,
        SLPG_HOTPLUG_TWO,
        SLPG_BLINK_GREEN,
        SLPG_COMM_ERROR
    } slpg_slave_state_type;

    typedef struct packed {
        logic configured;
        logic comm_active;
        logic comm_error;
    } slpg_client_flags_type;

    typedef struct packed {
        logic [PORTS-1:0] link;
        logic [PORTS-1:0] frame;
    } slpg_port_flags_type;

endpackage

// >>> logic/slpg_traffic_lamp.sv
// Purpose: one port's traffic flicker lamp
// Assumes: frame_in pulses once per sent or received frame
// Notes: an idle lamp's frame starts a 50 ms lit, 50 ms dark cycle; frames during a cycle queue just one more
module slpg_traffic_lamp (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic tick_in,
    input wire logic frame_in,
    output logic lamp_out
);
    import slpg_pkg::*;

    logic [11:0] ms_reg;
    logic busy_reg;
    logic pend_reg;

    // a frame during either half is remembered so heavy traffic gives 10 Hz
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ms_reg <= 12'h000;
            busy_reg <= 1'b0;
            pend_reg <= 1'b0;
            lamp_out <= 1'b0;
        end else begin
            if (!busy_reg) begin
                if (frame_in || pend_reg) begin
                    busy_reg <= 1'b1;
                    lamp_out <= 1'b1;
                    ms_reg <= 12'h000;
                    pend_reg <= 1'b0;
                end
            end else begin
                if (frame_in) begin
                    pend_reg <= 1'b1;
                end
                if (tick_in) begin
                    if (ms_reg == FLICK_LAST) begin
                        ms_reg <= 12'h000;
                        if (lamp_out) begin
                            lamp_out <= 1'b0;
                        end else begin
                            busy_reg <= 1'b0;
                        end
                    end else begin
                        ms_reg <= ms_reg + 12'h001;
                    end
                end
            end
        end
    end
endmodule

// >>> logic/slpg_top.sv
// Purpose: status lamp pattern generator for a fieldbus card
// Assumes: state flags are synchronous to clock_in
// Notes: duo lamps are driven as green/red pairs, orange is both
module slpg_top (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic client_mode_in,
    input wire slpg_pkg::slpg_slave_state_type slave_state_in,
    input wire slpg_pkg::slpg_client_flags_type client_flags_in,
    input wire slpg_pkg::slpg_port_flags_type port_flags_in,
    output logic phase_green_out,
    output logic phase_red_out,
    output logic run_green_out,
    output logic fault_red_out,
    output logic [1:0] link_lamp_out,
    output logic port0_traffic_lamp_out,
    output logic port1_traffic_lamp_out
);
    import slpg_pkg::*;

    logic [16:0] div_reg;
    logic tick_reg;
    logic [11:0] slot_ms_reg;
    logic [3:0] slot_reg;
    logic [11:0] blink_ms_reg;
    logic blink_reg;
    slpg_slave_state_type last_state_reg;
    logic [1:0] run_sel_reg;
    logic [1:0] run_sel_next;
    logic [1:0] run_last_reg;
    slpg_colour_type colour_next;
    logic restart;
    logic [3:0] slot_now;
    logic half_on;
    logic [1:0] traffic_lamp;

    // free-running millisecond tick shared by every pattern
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_reg <= 17'h00000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == TICK_LAST);
            if (div_reg == TICK_LAST) begin
                div_reg <= 17'h00000;
            end else begin
                div_reg <= div_reg + 17'h00001;
            end
        end
    end

    assign restart = (slave_state_in != last_state_reg);

    // 250 ms slot counter, twelve slots per 3 s cycle
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slot_ms_reg <= 12'h000;
            slot_reg <= 4'h0;
            last_state_reg <= SLPG_NON_REALTIME;
        end else begin
            last_state_reg <= slave_state_in;
            if (restart) begin
                slot_ms_reg <= 12'h000;
                slot_reg <= 4'h0;
            end else if (tick_reg) begin
                if (slot_ms_reg == SLOT_LAST) begin
                    slot_ms_reg <= 12'h000;
                    slot_reg <= (slot_reg == SLOTS_LAST) ? 4'h0
                                                         : slot_reg + 4'h1;
                end else begin
                    slot_ms_reg <= slot_ms_reg + 12'h001;
                end
            end
        end
    end

    // a state change shows slot zero at once, not the old slot's colour
    assign slot_now = restart ? 4'h0 : slot_reg;

    // even slots form the first half of each 2 Hz period
    assign half_on = ~slot_now[0];

    always_comb begin
        colour_next = SLPG_DARK;
        case (slave_state_in)
            SLPG_NON_REALTIME: colour_next = SLPG_DARK;
            SLPG_PHASE_ZERO: colour_next = SLPG_ORANGE;
            SLPG_PHASE_FOUR: colour_next = SLPG_GREEN;
            SLPG_PHASE_ONE, SLPG_PHASE_TWO, SLPG_PHASE_THREE: begin
                colour_next = SLPG_ORANGE;
                if (slot_now == 4'h0) begin
                    colour_next = SLPG_GREEN;
                end
                if (slave_state_in != SLPG_PHASE_ONE &&
                        slot_now == 4'h2) begin
                    colour_next = SLPG_GREEN;
                end
                if (slave_state_in == SLPG_PHASE_THREE &&
                        slot_now == 4'h4) begin
                    colour_next = SLPG_GREEN;
                end
            end
            SLPG_HOTPLUG_ONE, SLPG_HOTPLUG_TWO: begin
                colour_next = SLPG_GREEN;
                if (slot_now == 4'h0) begin
                    colour_next = SLPG_ORANGE;
                end
                if (slave_state_in == SLPG_HOTPLUG_TWO &&
                        slot_now == 4'h2) begin
                    colour_next = SLPG_ORANGE;
                end
            end
            SLPG_HOTPLUG_ZERO: begin
                colour_next = half_on ? SLPG_ORANGE : SLPG_GREEN;
            end
            SLPG_BLINK_GREEN: begin
                colour_next = half_on ? SLPG_GREEN : SLPG_DARK;
            end
            SLPG_COMM_ERROR: colour_next = SLPG_RED;
            default: colour_next = SLPG_DARK;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_green_out <= 1'b0;
            phase_red_out <= 1'b0;
        end else begin
            // slave lamp dark while the card runs the client protocol
            phase_green_out <= !client_mode_in &&
                (colour_next == SLPG_GREEN || colour_next == SLPG_ORANGE);
            phase_red_out <= !client_mode_in &&
                (colour_next == SLPG_RED || colour_next == SLPG_ORANGE);
        end
    end

    // client lamp selection: 0 dark, 1 steady, 2 blinking
    always_comb begin
        run_sel_next = 2'h0;
        if (client_flags_in.configured) begin
            run_sel_next = client_flags_in.comm_active ? 2'h1 : 2'h2;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_sel_reg <= 2'h0;
            run_last_reg <= 2'h0;
        end else begin
            run_sel_reg <= run_sel_next;
            run_last_reg <= run_sel_reg;
        end
    end

    // 5 Hz blink, restarted lit whenever the client lamp selection changes
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            blink_ms_reg <= 12'h000;
            blink_reg <= 1'b1;
        end else begin
            if (run_sel_reg != run_last_reg) begin
                blink_ms_reg <= 12'h000;
                blink_reg <= 1'b1;
            end else if (tick_reg) begin
                if (blink_ms_reg == BLINK5_LAST) begin
                    blink_ms_reg <= 12'h000;
                    blink_reg <= ~blink_reg;
                end else begin
                    blink_ms_reg <= blink_ms_reg + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_green_out <= 1'b0;
            fault_red_out <= 1'b0;
        end else begin
            if (!client_mode_in) begin
                run_green_out <= 1'b0;
                fault_red_out <= 1'b0;
            end else begin
                case (run_sel_reg)
                    2'h1: run_green_out <= 1'b1;
                    2'h2: run_green_out <= blink_reg;
                    default: run_green_out <= 1'b0;
                endcase
                // error has priority over the unconfigured blink
                if (client_flags_in.comm_error) begin
                    fault_red_out <= 1'b1;
                end else if (!client_flags_in.configured) begin
                    fault_red_out <= blink_reg;
                end else begin
                    fault_red_out <= 1'b0;
                end
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            always_ff @(posedge clock_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    link_lamp_out[p] <= 1'b0;
                end else begin
                    link_lamp_out[p] <= port_flags_in.link[p];
                end
            end
            slpg_traffic_lamp u_traffic (
                .clock_in(clock_in),
                .rst_b_in(rst_b_in),
                .tick_in(tick_reg),
                .frame_in(port_flags_in.frame[p]),
                .lamp_out(traffic_lamp[p])
            );
        end
    endgenerate

    // traffic lamps are already flops inside the per-port module
    assign port0_traffic_lamp_out = traffic_lamp[0];
    assign port1_traffic_lamp_out = traffic_lamp[1];
endmodule

// >>> tb/slpg_monitor.sv
// Purpose: port-level checks for the status lamp pattern generator
// Assumes: flags synchronous to clock_in, async active-low reset
// Notes: only slot zero of the phase and hotplug one/two patterns is checked; slots are 250 ms long
module slpg_monitor (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic client_mode_in,
    input wire slpg_pkg::slpg_slave_state_type slave_state_in,
    input wire slpg_pkg::slpg_client_flags_type client_flags_in,
    input wire slpg_pkg::slpg_port_flags_type port_flags_in,
    input wire logic phase_green_out,
    input wire logic phase_red_out,
    input wire logic run_green_out,
    input wire logic fault_red_out,
    input wire logic [1:0] link_lamp_out,
    input wire logic port0_traffic_lamp_out,
    input wire logic port1_traffic_lamp_out
);
    import slpg_pkg::*;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence slave_in(slpg_slave_state_type s);
        !client_mode_in && slave_state_in == s;
    endsequence
    // run selection is registered, so flags must hold two cycles
    sequence run_steady;
        (client_mode_in && client_flags_in.configured &&
            client_flags_in.comm_active)[*2];
    endsequence
    sequence unconfigured;
        (client_mode_in && !client_flags_in.configured)[*2];
    endsequence
    phase_four_green_a: assert property (
        slave_in(SLPG_PHASE_FOUR) |=> phase_green_out && !phase_red_out)
        else $error("phase four lamp");
    phase_zero_orange_a: assert property (
        slave_in(SLPG_PHASE_ZERO) |=> phase_green_out && phase_red_out)
        else $error("phase zero lamp");
    non_realtime_dark_a: assert property (
        slave_in(SLPG_NON_REALTIME) |=> !phase_green_out && !phase_red_out)
        else $error("non-realtime lamp");
    green_slot_zero_a: assert property (
        $changed(slave_state_in) && !client_mode_in &&
        slave_state_in inside {SLPG_PHASE_ONE, SLPG_PHASE_TWO,
        SLPG_PHASE_THREE} |=> phase_green_out && !phase_red_out)
        else $error("green pattern slot zero");
    orange_slot_zero_a: assert property (
        $changed(slave_state_in) && !client_mode_in &&
        slave_state_in inside {SLPG_HOTPLUG_ONE, SLPG_HOTPLUG_TWO}
        |=> phase_green_out && phase_red_out)
        else $error("orange pattern slot zero");
    run_steady_a: assert property (
        run_steady |=> run_green_out)
        else $error("run lamp not green");
    run_dark_a: assert property (
        unconfigured |=> !run_green_out)
        else $error("run lamp lit unconfigured");
    fault_error_a: assert property (
        client_mode_in && client_flags_in.comm_error |=> fault_red_out)
        else $error("fault lamp");
    slave_quiet_a: assert property (
        (!client_mode_in)[*3] |-> !run_green_out && !fault_red_out)
        else $error("client lamps in slave");
    client_quiet_a: assert property (
        client_mode_in |=> !phase_green_out && !phase_red_out)
        else $error("phase lamp in client");
    link_follow_a: assert property (
        port_flags_in.link != link_lamp_out
        |=> link_lamp_out == $past(port_flags_in.link))
        else $error("link lamp");
    traffic_hold_a: assert property (
        $rose(port0_traffic_lamp_out) |=> port0_traffic_lamp_out[*8])
        else $error("traffic lamp too short");
endmodule
bind slpg_top slpg_monitor mon (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .client_mode_in(client_mode_in), .slave_state_in(slave_state_in),
    .client_flags_in(client_flags_in), .port_flags_in(port_flags_in),
    .phase_green_out(phase_green_out), .phase_red_out(phase_red_out),
    .run_green_out(run_green_out), .fault_red_out(fault_red_out),
    .link_lamp_out(link_lamp_out),
    .port0_traffic_lamp_out(port0_traffic_lamp_out),
    .port1_traffic_lamp_out(port1_traffic_lamp_out));

// >>> tb/test_status_led_pattern_generator.sv
// Purpose: self-checking bench for the status lamp pattern generator
// Assumes: run stays below one tick (100000 cycles), so no blink toggles
// Notes: timing of later slots needs seconds of run time; the assertions check slot zero only
module test_status_led_pattern_generator;
    timeunit 1ns;
    timeprecision 1ns;
    import slpg_pkg::*;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic client_mode_in = 1'b0;
    slpg_slave_state_type slave_state_in = SLPG_NON_REALTIME;
    slpg_client_flags_type client_flags_in = '0;
    slpg_port_flags_type port_flags_in = '0;
    logic phase_green_out, phase_red_out, run_green_out, fault_red_out;
    logic [1:0] link_lamp_out;
    logic port0_traffic_lamp_out, port1_traffic_lamp_out;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'h487a;
    slpg_top dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .client_mode_in(client_mode_in), .slave_state_in(slave_state_in),
        .client_flags_in(client_flags_in), .port_flags_in(port_flags_in),
        .phase_green_out(phase_green_out), .phase_red_out(phase_red_out),
        .run_green_out(run_green_out), .fault_red_out(fault_red_out),
        .link_lamp_out(link_lamp_out),
        .port0_traffic_lamp_out(port0_traffic_lamp_out),
        .port1_traffic_lamp_out(port1_traffic_lamp_out));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic stop_test;
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [1:0] exp,
            input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    // slot zero colour as {green, red}; orange lights both
    function automatic logic [1:0] phase_exp(slpg_slave_state_type s);
        case (s)
            SLPG_NON_REALTIME: return 2'b00;
            SLPG_PHASE_ZERO, SLPG_HOTPLUG_ZERO: return 2'b11;
            SLPG_HOTPLUG_ONE, SLPG_HOTPLUG_TWO: return 2'b11;
            SLPG_COMM_ERROR: return 2'b01;
            default: return 2'b10;
        endcase
    endfunction
    // {run, fault}; blinks are still in their first lit half
    function automatic logic [1:0] client_exp(slpg_client_flags_type f);
        return {f.configured, f.comm_error | !f.configured};
    endfunction
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        slpg_slave_state_type st;
        slpg_client_flags_type cf;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(negedge clock_in);
        check("phase after reset", 2'b00,
            {phase_green_out, phase_red_out});
        check("client after reset", 2'b00,
            {run_green_out, fault_red_out});
        for (int i = 0; i < 60; i++) begin
            @(posedge clock_in);
            st = slpg_slave_state_type'(($random(seed) & 32'h7fff) % 11);
            slave_state_in <= st;
            port_flags_in.link <= 2'($random(seed));
            @(posedge clock_in);
            @(negedge clock_in);
            check("phase lamp", phase_exp(st),
                {phase_green_out, phase_red_out});
            check("link lamp", port_flags_in.link,
                link_lamp_out);
            check("client in slave", 2'b00,
                {run_green_out, fault_red_out});
            check("traffic idle", 2'b00,
                {port1_traffic_lamp_out, port0_traffic_lamp_out});
            repeat (($random(seed) & 32'h7) + 1) @(posedge clock_in);
        end
        @(posedge clock_in);
        client_mode_in <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clock_in);
            cf = (i < 8) ? 3'(i) : 3'($random(seed));
            client_flags_in <= cf;
            repeat (3) @(posedge clock_in);
            @(negedge clock_in);
            check("run and fault", client_exp(cf),
                {run_green_out, fault_red_out});
            check("phase in client", 2'b00,
                {phase_green_out, phase_red_out});
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge clock_in);
            port_flags_in.frame <= 2'(p + 1);
            @(posedge clock_in);
            port_flags_in.frame <= 2'b00;
            @(negedge clock_in);
            check("traffic lit", 2'(p ? 3 : 1),
                {port1_traffic_lamp_out, port0_traffic_lamp_out});
            repeat (200) @(posedge clock_in);
            @(negedge clock_in);
            check("traffic held", 2'(p ? 3 : 1),
                {port1_traffic_lamp_out, port0_traffic_lamp_out});
        end
        stop_test();
    end
endmodule
